/* hdl/exception_syndrome_encoder.sv */
// exception syndrome encoder with wishbone register access
//
// Summary of operation
// [RL1] call syndrome: immediate low, upper bits zero
// [RL2] supervisor call immediate from long or short
// [RL3] conditional supervisor call immediate is don't-care
// [RL4] trapped supervisor call uses class 0b010001
// [RL5] fetch address-invalid only with external code
// [RL6] external abort class zero when not external
// [RL7] fetch fault codes; debug only with 0b100001
// [RL8] fetch aborts use class 0b100000
// [RL9] illegal return / pc alignment: syndrome zero
// [RL10] syndrome-valid clear forces bits 23:14 zero
// [RL11] valid only for qualifying stage 2 accesses
// [RL12] debug memory mode makes valid bits loose
// [RL13] unprivileged variants never give valid syndrome
// [RL14] access size in bits 23:22
// [RL15] sign extend only for byte/half/word loads
// [RL16] transfer register number in bits 19:16
// [RL17] acquire/release flag in bit 14
// [RL18] data address-invalid only with external code
// [RL19] cache maintenance bit zero for asynchronous aborts
// [RL20] write-not-read, forced one for maintenance
// [RL21] data fault code set
// [RL22] data aborts use class 0b100100
// [RL23] syndrome written whole in the taking cycle
`timescale 1ns/100ps
module exception_syndrome_encoder (
    input wire logic clk_i, // core clock, 250 MHz
    input wire logic rst_i, // sync reset, high
    input wire syndrome_pkg::exc_report_s exc_i, // exception report
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [3:0] sel_i, // wishbone byte selects
    input wire logic [7:0] adr_i, // wishbone byte address
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone ack
    output logic [24:0] instr_specific_syndrome_o, // held syndrome
    output logic [5:0] exception_class_code_o, // held class
    output logic syndrome_update_o // pulse: new syndrome written
);
    import syndrome_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);


    // ************************************************************
    // fault code checks
    // ************************************************************
    function automatic logic fetch_code_ok(input logic [5:0] c);
        fetch_code_ok = (c == FSC_TRANSL) || (c == FSC_PERM) ||
            (c == FSC_EXT) || (c == FSC_PARITY) || (c == FSC_DEBUG);
    endfunction

    function automatic logic data_code_ok(input logic [5:0] c);
        data_code_ok = fetch_code_ok(c) || (c == FSC_SERR) ||
            (c == FSC_SERR_PAR) || (c == FSC_ALIGN) ||
            (c == FSC_LOCKDOWN) || (c == FSC_EXCL);
    endfunction

    // ************************************************************
    // supervisor / hypervisor call
    // ************************************************************
    logic [15:0] call_imm;
    logic [ISS_W-1:0] call_iss;
    logic [5:0] call_ec;

    // [RL2] immediate by encoding form
    // [RL3] conditional call passes the immediate through unchecked
    assign call_imm = (exc_i.call_form == CALL_HVC) ? exc_i.call_immediate :
        (exc_i.call_form == CALL_SVC_WIDE) ? exc_i.long_immediate[15:0] :
        {8'h00, exc_i.short_immediate};
    // [RL1] upper bits zero
    assign call_iss = {9'h000, call_imm};
    // [RL4] trapped supervisor call class
    assign call_ec = (exc_i.call_form == CALL_HVC) ? EC_HYP_CALL : EC_CALL;

    // ************************************************************
    // instruction fetch abort
    // ************************************************************
    logic [5:0] fetch_code;
    logic [ISS_W-1:0] fetch_iss;
    logic [5:0] fetch_ec;
    logic fetch_dbg;

    // [RL7] unknown codes fold to translation, debug follows class
    assign fetch_dbg = exc_i.fetch_debug;
    assign fetch_code = fetch_dbg ? FSC_DEBUG :
        (fetch_code_ok(exc_i.fault_code) &&
        exc_i.fault_code != FSC_DEBUG) ? exc_i.fault_code : FSC_TRANSL;
    // [RL5] [RL6] address-invalid and external class gating
    always_comb begin
        fetch_iss = '0;
        fetch_iss[5:0] = fetch_code;
        fetch_iss[POS_FNV] = (fetch_code == FSC_EXT) &
            exc_i.fault_addr_invalid;
        fetch_iss[POS_EA] = exc_i.is_external & exc_i.ext_abort_class;
    end
    // [RL8] fetch abort class
    assign fetch_ec = fetch_dbg ? EC_FETCH_DBG : EC_FETCH;

    // ************************************************************
    // data abort
    // ************************************************************
    logic [5:0] data_code;
    logic iss_ok;
    logic [ISS_W-1:0] data_iss;
    logic [5:0] data_ec;
    logic is_cm;

    // [RL21] [RL22] code set, debug code only with data class
    assign data_code = data_code_ok(exc_i.fault_code) ?
        exc_i.fault_code : FSC_TRANSL;
    // [RL11] [RL13] qualifying stage 2 single access
    // [RL12] debug memory mode treated as not qualifying
    assign iss_ok = exc_i.stage2 & exc_i.single_ldst & ~exc_i.writeback &
        ~exc_i.uses_pc & ~exc_i.unpriv & ~exc_i.debug_mem_mode;
    assign is_cm = exc_i.synchronous & exc_i.cache_maint;

    always_comb begin
        data_iss = '0;
        data_iss[5:0] = data_code;
        // [RL10] valid bit gates 23:14
        data_iss[POS_VALID] = iss_ok;
        if (iss_ok) begin
            // [RL14] access size
            data_iss[POS_SIZE +: 2] = exc_i.access_size;
            // [RL15] sign extension only for loads below doubleword
            data_iss[POS_SEXT] = exc_i.is_load & exc_i.sign_ext &
                (exc_i.access_size != SIZE_DWORD);
            // [RL16] transfer register
            data_iss[POS_REG +: 4] = exc_i.transfer_register;
            // [RL17] acquire/release
            data_iss[POS_ACQREL] = exc_i.acq_rel;
        end
        // [RL18] address-invalid only with external code
        data_iss[POS_FNV] = (data_code == FSC_EXT) &
            exc_i.fault_addr_invalid;
        // [RL6] external class
        data_iss[POS_EA] = exc_i.is_external & exc_i.ext_abort_class;
        // [RL19] maintenance bit only synchronous
        data_iss[POS_CM] = is_cm;
        // [RL20] write-not-read, forced for maintenance
        data_iss[POS_WNR] = is_cm | exc_i.is_write;
    end
    assign data_ec = EC_DATA;

    // ************************************************************
    // format select
    // ************************************************************
    syndrome_s sel_syn;
    syndrome_s held_syn;
    logic take;
    logic [31:0] ctrl_q;

    assign take = exc_i.take & ~ctrl_q[CTRL_HOLD_BIT];
    // [RL9] illegal state and pc alignment give all zero
    always_comb begin
        sel_syn = '0;
        case (exc_i.kind)
            K_CALL: begin
                sel_syn.exception_class_code = call_ec;
                sel_syn.instr_specific_syndrome = call_iss;
            end
            K_FETCH: begin
                sel_syn.exception_class_code = fetch_ec;
                sel_syn.instr_specific_syndrome = fetch_iss;
            end
            K_ILLEGAL: begin
                sel_syn.exception_class_code = exc_i.pc_align ?
                    EC_PC_ALIGN : EC_ILLEGAL;
                sel_syn.instr_specific_syndrome = '0;
            end
            K_DATA: begin
                sel_syn.exception_class_code = data_ec;
                sel_syn.instr_specific_syndrome = data_iss;
            end
            default: begin
                sel_syn = '0;
            end
        endcase
    end

    // [RL23] whole syndrome loaded at the taking edge
    syndrome_reg syndrome_reg_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(take),
        .data_i(sel_syn),
        .data_o(held_syn)
    );

    // ************************************************************
    // register access
    // ************************************************************
    logic bus_req;
    logic wr_ctrl;
    logic [31:0] ctrl_d;
    logic valid_q;
    logic over_q;
    logic [15:0] count_q;
    logic update_q;
    logic [31:0] rd_mux;
    logic [31:0] rdata_q;
    logic clr;

    wb_slave wb_slave_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .ack_o(ack_o),
        .req_o(bus_req)
    );

    assign wr_ctrl = bus_req & we_i & (adr_i == OFF_CONTROL) & sel_i[0];
    assign ctrl_d = {ctrl_q[31:2], dat_i[CTRL_HOLD_BIT], 1'b0};
    assign clr = wr_ctrl & dat_i[CTRL_CLEAR_BIT];

    assign rd_mux = (adr_i == OFF_SYNDROME) ? {1'b0, held_syn} :
        (adr_i == OFF_STATUS) ? {30'h0, over_q, valid_q} :
        (adr_i == OFF_CONTROL) ? ctrl_q :
        (adr_i == OFF_COUNT) ? {16'h0, count_q} : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= RST_CONTROL;
            rdata_q <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_d;
            end
            if (bus_req & ~we_i) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // status: set wins over clear for valid, clear wins over set for overrun
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            over_q <= 1'b0;
            count_q <= 16'h0;
            update_q <= 1'b0;
        end else begin
            update_q <= take;
            valid_q <= take | (valid_q & ~clr);
            over_q <= (take & valid_q & ~clr) | (over_q & ~clr);
            if (take) begin
                count_q <= count_q + 16'h1;
            end
        end
    end

    assign dat_o = rdata_q;
    assign instr_specific_syndrome_o = held_syn.instr_specific_syndrome;
    assign exception_class_code_o = held_syn.exception_class_code;
    assign syndrome_update_o = update_q;

    // ************************************************************
    // assertions
    // ************************************************************
    a_call_upper_zero: assert property ( // [RL1]
        syndrome_update_o && exception_class_code_o == EC_HYP_CALL
        |-> instr_specific_syndrome_o[24:16] == 9'h000)
        else $error("call syndrome upper bits not zero");
    a_call_class: assert property ( // [RL4]
        take && exc_i.kind == K_CALL && exc_i.call_form != CALL_HVC
        |=> exception_class_code_o == 6'h11)
        else $error("supervisor call class wrong");
    a_fetch_fnv: assert property ( // [RL5]
        syndrome_update_o && exception_class_code_o == EC_FETCH &&
        instr_specific_syndrome_o[5:0] != 6'h10
        |-> !instr_specific_syndrome_o[10])
        else $error("fetch address-invalid with non-external code");
    a_fetch_class: assert property ( // [RL8]
        take && exc_i.kind == K_FETCH && !exc_i.fetch_debug
        |=> exception_class_code_o == 6'h20)
        else $error("fetch class wrong");
    a_illegal_zero: assert property ( // [RL9]
        take && exc_i.kind == K_ILLEGAL
        |=> instr_specific_syndrome_o == 25'h0)
        else $error("illegal syndrome not zero");
    a_valid_gates: assert property ( // [RL10]
        exception_class_code_o == EC_DATA && !instr_specific_syndrome_o[24]
        |-> instr_specific_syndrome_o[23:14] == 10'h0)
        else $error("syndrome bits set while not valid");
    a_unpriv_invalid: assert property ( // [RL13]
        take && exc_i.kind == K_DATA && (exc_i.unpriv || exc_i.writeback)
        |=> !instr_specific_syndrome_o[24])
        else $error("writeback access gave valid syndrome");
    a_cm_wnr: assert property ( // [RL20]
        take && exc_i.kind == K_DATA && exc_i.synchronous &&
        exc_i.cache_maint |=> instr_specific_syndrome_o[8] &&
        instr_specific_syndrome_o[6])
        else $error("maintenance fault not marked write");
    a_async_cm: assert property ( // [RL19]
        take && exc_i.kind == K_DATA && !exc_i.synchronous
        |=> !instr_specific_syndrome_o[8])
        else $error("maintenance bit on asynchronous abort");
    a_data_class: assert property ( // [RL22]
        take && exc_i.kind == K_DATA |=> exception_class_code_o == 6'h24)
        else $error("data class wrong");
    a_whole_update: assert property ( // [RL23]
        !$past(take) |-> $stable(instr_specific_syndrome_o) &&
        $stable(exception_class_code_o))
        else $error("syndrome changed without exception");

    a_svc_wide_imm: assert property ( // [RL2]
        take && exc_i.kind == K_CALL && exc_i.call_form == CALL_SVC_WIDE &&
        !exc_i.call_cond |=> instr_specific_syndrome_o[15:0] ==
        $past(exc_i.long_immediate[15:0]))
        else $error("wide call immediate wrong");

    a_ext_class: assert property ( // [RL6]
        take && exc_i.kind inside {K_FETCH, K_DATA} && !exc_i.is_external
        |=> !instr_specific_syndrome_o[9])
        else $error("external class on other abort");

    a_fetch_dbg: assert property ( // [RL7]
        syndrome_update_o && (exception_class_code_o == EC_FETCH ||
        exception_class_code_o == EC_FETCH_DBG) |->
        (instr_specific_syndrome_o[5:0] == FSC_DEBUG) ==
        (exception_class_code_o == EC_FETCH_DBG))
        else $error("fetch debug code and class differ");

    a_isv_stage2: assert property ( // [RL11]
        take && exc_i.kind == K_DATA && !(exc_i.stage2 && exc_i.single_ldst)
        |=> !instr_specific_syndrome_o[24])
        else $error("valid syndrome on other abort");

    a_isv_fields: assert property ( // [RL16]
        take && exc_i.kind == K_DATA && iss_ok |=>
        instr_specific_syndrome_o[19:16] == $past(exc_i.transfer_register)
        && instr_specific_syndrome_o[14] == $past(exc_i.acq_rel))
        else $error("register or acquire field wrong");

    a_data_fnv: assert property ( // [RL18]
        syndrome_update_o && exception_class_code_o == EC_DATA &&
        instr_specific_syndrome_o[5:0] != FSC_EXT
        |-> !instr_specific_syndrome_o[10])
        else $error("data address-invalid on other code");
endmodule

/* hdl/syndrome_pkg.sv */
// shared constants and carriers for the exception syndrome encoder
package syndrome_pkg;

    // ************************************************************
    // register map (word offsets are byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_SYNDROME = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0C;
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_OVER_BIT = 1;

    // ************************************************************
    // exception classes
    // ************************************************************
    localparam logic [5:0] EC_CALL = 6'h11;
    localparam logic [5:0] EC_FETCH = 6'h20;
    localparam logic [5:0] EC_FETCH_DBG = 6'h21;
    localparam logic [5:0] EC_DATA = 6'h24;
    localparam logic [5:0] EC_ILLEGAL = 6'h0E;
    localparam logic [5:0] EC_PC_ALIGN = 6'h22;
    localparam logic [5:0] EC_HYP_CALL = 6'h12;

    // ************************************************************
    // fault codes
    // ************************************************************
    localparam logic [5:0] FSC_TRANSL = 6'h04;
    localparam logic [5:0] FSC_PERM = 6'h0C;
    localparam logic [5:0] FSC_EXT = 6'h10;
    localparam logic [5:0] FSC_PARITY = 6'h18;
    localparam logic [5:0] FSC_SERR = 6'h11;
    localparam logic [5:0] FSC_SERR_PAR = 6'h19;
    localparam logic [5:0] FSC_ALIGN = 6'h21;
    localparam logic [5:0] FSC_DEBUG = 6'h22;
    localparam logic [5:0] FSC_LOCKDOWN = 6'h34;
    localparam logic [5:0] FSC_EXCL = 6'h35;

    // ************************************************************
    // syndrome field positions
    // ************************************************************
    localparam int ISS_W = 25;
    localparam int POS_VALID = 24;
    localparam int POS_SIZE = 22;
    localparam int POS_SEXT = 21;
    localparam int POS_REG = 16;
    localparam int POS_ACQREL = 14;
    localparam int POS_FNV = 10;
    localparam int POS_EA = 9;
    localparam int POS_CM = 8;
    localparam int POS_WNR = 6;
    localparam logic [1:0] SIZE_DWORD = 2'h3;

    typedef enum logic [3:0] {
        K_CALL = 4'h1,
        K_FETCH = 4'h2,
        K_ILLEGAL = 4'h4,
        K_DATA = 4'h8
    } exc_kind_e;

    typedef enum logic [1:0] {
        CALL_HVC = 2'h0,
        CALL_SVC_WIDE = 2'h1,
        CALL_SVC_SHORT = 2'h2
    } call_form_e;

    // one exception report from the pipeline / memory system
    typedef struct packed {
        logic take;
        exc_kind_e kind;
        logic pc_align;
        call_form_e call_form;
        logic call_cond;
        logic general_trap_enable;
        logic [23:0] long_immediate;
        logic [15:0] call_immediate;
        logic [7:0] short_immediate;
        logic fetch_debug;
        logic [5:0] fault_code;
        logic fault_addr_invalid;
        logic is_external;
        logic ext_abort_class;
        logic stage2;
        logic single_ldst;
        logic writeback;
        logic uses_pc;
        logic unpriv;
        logic debug_mem_mode;
        logic [1:0] access_size;
        logic is_load;
        logic sign_ext;
        logic [3:0] transfer_register;
        logic acq_rel;
        logic synchronous;
        logic cache_maint;
        logic is_write;
    } exc_report_s;

    typedef struct packed {
        logic [5:0] exception_class_code;
        logic [ISS_W-1:0] instr_specific_syndrome;
    } syndrome_s;

endpackage

/* hdl/syndrome_reg.sv */
// holding register for the hypervisor syndrome word
`timescale 1ns/100ps
module syndrome_reg (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset, high
    input wire logic load_i, // take a new syndrome
    input wire syndrome_pkg::syndrome_s data_i, // new syndrome
    output syndrome_pkg::syndrome_s data_o // held syndrome
);
    import syndrome_pkg::*;

    syndrome_s hold_q;

    // whole word replaced in one edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= '0;
        end else if (load_i) begin
            hold_q <= data_i;
        end
    end

    assign data_o = hold_q;
endmodule

/* hdl/wb_slave.sv */
// classic wishbone slave front end with registered ack
`timescale 1ns/100ps
module wb_slave (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset, high
    input wire logic cyc_i, // bus cycle
    input wire logic stb_i, // strobe
    output logic ack_o, // registered ack
    output logic req_o // one-cycle access accepted
);
    logic ack_q;

    // one ack per request, then drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    assign ack_o = ack_q;
    assign req_o = cyc_i & stb_i & ~ack_q;
endmodule

/* verif/exc_reporter.sv */
// pipeline-side model that reports one exception per request
`timescale 1ns/100ps
module exc_reporter (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset, high
    input wire syndrome_pkg::exc_report_s req_i, // report to send
    input wire logic go_i, // send req_i next cycle
    output syndrome_pkg::exc_report_s exc_o // report to the encoder
);
    import syndrome_pkg::*;
    // ********
    // report launch
    // ********
    // fields toggle while idle so nothing stale looks valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exc_o <= '0;
        end else if (go_i) begin
            exc_o <= {1'b1, req_i[$bits(exc_report_s)-2:0]};
        end else begin
            exc_o <= {1'b0, ~exc_o[$bits(exc_report_s)-2:0]};
        end
    end
endmodule

/* verif/tb_exception_syndrome_encoder.sv */
// self-checking bench for the exception syndrome encoder
`timescale 1ns/100ps
module tb_exception_syndrome_encoder;
    import syndrome_pkg::*;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
    // ********
    // signals
    // ********
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
    logic [3:0] sel_i = 4'h0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, syndrome_update_o;
    logic [24:0] instr_specific_syndrome_o;
    logic [5:0] exception_class_code_o;
    exc_report_s req = '0, exc;
    syndrome_s last = '0;
    int err_total = 0, checks = 0, cycles = 0;

    always #2 clk_i = ~clk_i;

    exc_reporter exc_reporter_inst (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(req), .go_i(go), .exc_o(exc));
    exception_syndrome_encoder exception_syndrome_encoder_inst (
        .clk_i(clk_i), .rst_i(rst_i), .exc_i(exc), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .instr_specific_syndrome_o(instr_specific_syndrome_o),
        .exception_class_code_o(exception_class_code_o),
        .syndrome_update_o(syndrome_update_o));
    // ********
    // expected syndrome
    // ********
    function automatic syndrome_s exp_syn(exc_report_s r);
        syndrome_s s;
        logic [5:0] c;
        s = '0;
        c = r.fetch_debug ? FSC_DEBUG : r.fault_code;
        case (r.kind)
            K_CALL: begin
                s.exception_class_code =
                    (r.call_form == CALL_HVC) ? EC_HYP_CALL : EC_CALL;
                s.instr_specific_syndrome[15:0] =
                    (r.call_form == CALL_HVC) ? r.call_immediate :
                    (r.call_form == CALL_SVC_WIDE) ? r.long_immediate[15:0] :
                    {8'h00, r.short_immediate};
            end
            K_FETCH: begin
                s.exception_class_code = r.fetch_debug ? EC_FETCH_DBG : EC_FETCH;
                s.instr_specific_syndrome[5:0] = c;
                s.instr_specific_syndrome[10] =
                    r.fault_addr_invalid && (c == FSC_EXT);
                s.instr_specific_syndrome[9] = r.is_external & r.ext_abort_class;
            end
            K_ILLEGAL: begin
                s.exception_class_code = r.pc_align ? EC_PC_ALIGN : EC_ILLEGAL;
            end
            default: begin
                s = exp_data(r);
            end
        endcase
        return s;
    endfunction

    function automatic syndrome_s exp_data(exc_report_s r);
        syndrome_s s;
        logic v;
        s = '0;
        s.exception_class_code = EC_DATA;
        v = r.stage2 & r.single_ldst & ~r.writeback & ~r.uses_pc &
            ~r.unpriv & ~r.debug_mem_mode;
        s.instr_specific_syndrome[24] = v;
        if (v) begin
            s.instr_specific_syndrome[23:22] = r.access_size;
            s.instr_specific_syndrome[21] = r.sign_ext & r.is_load &
                (r.access_size != SIZE_DWORD);
            s.instr_specific_syndrome[19:16] = r.transfer_register;
            s.instr_specific_syndrome[14] = r.acq_rel;
        end
        s.instr_specific_syndrome[10] =
            r.fault_addr_invalid && (r.fault_code == FSC_EXT);
        s.instr_specific_syndrome[9] = r.is_external & r.ext_abort_class;
        s.instr_specific_syndrome[8] = r.synchronous & r.cache_maint;
        s.instr_specific_syndrome[6] =
            (r.synchronous & r.cache_maint) | r.is_write;
        s.instr_specific_syndrome[5:0] = r.fault_code;
        return s;
    endfunction

    function automatic exc_report_s base(exc_kind_e k);
        exc_report_s r;
        r = '1;
        r.take = 1'b0;
        r.kind = k;
        r.call_cond = 1'b0;
        r.fetch_debug = 1'b0;
        r.debug_mem_mode = 1'b0;
        return r;
    endfunction
    // ********
    // shared drivers
    // ********
    task automatic run(input exc_report_s r, input logic held);
        syndrome_s e;
        e = held ? last : exp_syn(r);
        @(posedge clk_i);
        req <= r;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(exception_class_code_o, e.exception_class_code)
        `CHK(instr_specific_syndrome_o, e.instr_specific_syndrome)
        `CHK(syndrome_update_o, !held)
        last = e;
        @(posedge clk_i);
        #1;
        `CHK(syndrome_update_o, 1'b0)
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_calls;
        exc_report_s r;
        r = base(K_CALL);
        r.long_immediate = 24'hA5C3E1;
        r.call_immediate = 16'h1234;
        r.short_immediate = 8'h9B;
        r.call_form = CALL_HVC;
        run(r, 1'b0);
        r.call_form = CALL_SVC_WIDE;
        run(r, 1'b0);
        r.call_form = CALL_SVC_SHORT;
        run(r, 1'b0);
    endtask

    task automatic t_fetch;
        exc_report_s r;
        logic [5:0] cd [4] = '{FSC_TRANSL, FSC_PERM, FSC_EXT, FSC_PARITY};
        r = base(K_FETCH);
        foreach (cd[i]) begin
            r.fault_code = cd[i];
            r.is_external = (cd[i] == FSC_EXT);
            run(r, 1'b0);
        end
        r.fetch_debug = 1'b1;
        run(r, 1'b0);
        r = base(K_ILLEGAL);
        r.pc_align = 1'b0;
        run(r, 1'b0);
        r.pc_align = 1'b1;
        run(r, 1'b0);
    endtask

    task automatic t_isv;
        exc_report_s r;
        r = base(K_DATA);
        r.fault_code = FSC_PERM;
        {r.writeback, r.uses_pc, r.unpriv, r.is_load} = 4'h1;
        r.transfer_register = 4'hB;
        for (int s = 0; s < 4; s++) begin
            r.access_size = s[1:0];
            run(r, 1'b0);
        end
        r.is_load = 1'b0;
        r.acq_rel = 1'b0;
        run(r, 1'b0);
        r.writeback = 1'b1;
        run(r, 1'b0);
        r.writeback = 1'b0;
        r.unpriv = 1'b1;
        run(r, 1'b0);
        r.unpriv = 1'b0;
        r.debug_mem_mode = 1'b1;
        run(r, 1'b0);
        r.debug_mem_mode = 1'b0;
        r.stage2 = 1'b0;
        run(r, 1'b0);
    endtask

    task automatic t_codes;
        exc_report_s r;
        logic [5:0] cd [10] = '{FSC_TRANSL, FSC_PERM, FSC_EXT, FSC_PARITY,
            FSC_SERR, FSC_SERR_PAR, FSC_ALIGN, FSC_DEBUG, FSC_LOCKDOWN,
            FSC_EXCL};
        r = base(K_DATA);
        foreach (cd[i]) begin
            r.fault_code = cd[i];
            r.is_external = (cd[i] == FSC_EXT);
            {r.is_write, r.cache_maint, r.synchronous} = i[2:0];
            run(r, 1'b0);
        end
    endtask

    task automatic t_regs;
        exc_report_s r;
        wb(1'b0, OFF_SYNDROME, 32'h0);
        `CHK(rd, {1'b0, last})
        wb(1'b0, OFF_COUNT, 32'h0);
        `CHK(rd, 32'h1D)
        wb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd, 32'h3)
        wb(1'b1, OFF_CONTROL, 32'h1);
        wb(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'b1, OFF_CONTROL, 32'h2);
        r = base(K_ILLEGAL);
        r.pc_align = 1'b0;
        run(r, 1'b1);
        wb(1'b1, OFF_CONTROL, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h0)
        run(r, 1'b0);
    endtask
    // ********
    // sequence and verdict
    // ********
    task automatic test_done;
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(instr_specific_syndrome_o, 25'h0)
        wb(1'b0, OFF_CONTROL, 32'h0);
        `CHK(rd, RST_CONTROL)
        t_calls();
        t_fetch();
        t_isv();
        t_codes();
        t_regs();
        test_done();
    end
endmodule
